// File: design/sarc_controller.v
// register file and successive-approximation sequencer
`timescale 1ns/1ps
`include "sarc_defines.vh"
module sarc_controller (
  input wire clk_in,
  input wire nrst_in,
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire standby_in,
  input wire subclk_x4_tick_in,
  input wire comparator_in,
  output reg [7:0] tap_select_out,
  output reg [2:0] channel_route_out,
  output reg sample_out,
  output reg bandgap_enable_out,
  output reg conversion_done_irq_out
);
  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_COMPARE = 3'b100;
  reg [7:0] mode_q;
  reg [7:0] clksrc_q;
  reg [7:0] chan_q;
  reg [7:0] result_q;
  reg [7:0] result_d;
  reg [7:0] approx_q;
  reg [7:0] approx_d;
  reg [7:0] trial_q;
  reg [7:0] trial_d;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg sample_cnt_q;
  reg sample_cnt_d;
  reg done_d;
  reg [7:0] step_len;
  wire wr_mode;
  wire wr_clksrc;
  wire wr_chan;
  wire ctl_write;
  wire running;
  wire tick;
  wire step;
  wire [2:0] tsel;
  ////////////////////////////////////////////////////////////////////////
  assign wr_mode = wr_in && (addr_in == `SARC_ADDR_MODE);
  assign wr_clksrc = wr_in && (addr_in == `SARC_ADDR_CLKSRC);
  assign wr_chan = wr_in && (addr_in == `SARC_ADDR_CHAN);
  assign ctl_write = wr_mode || wr_chan;
  assign tsel = mode_q[`SARC_TSEL_HI:`SARC_TSEL_LO];
  // conversion halts while the system is in standby
  assign running = mode_q[`SARC_BIT_ENABLE] && !standby_in; // RULE1 RULE18
  // x4 subclock paces the steps when selected
  assign tick = clksrc_q[`SARC_BIT_SUBCLK] ? subclk_x4_tick_in : 1'b1; // RULE5
  always @*
  begin
    case (tsel)
      `SARC_TSEL_144: step_len = `SARC_STEP_144; // RULE3
      `SARC_TSEL_120: step_len = `SARC_STEP_120; // RULE3
      `SARC_TSEL_96: step_len = `SARC_STEP_96; // RULE3
      `SARC_TSEL_72: step_len = `SARC_STEP_72; // RULE3
      `SARC_TSEL_60: step_len = `SARC_STEP_60;
      `SARC_TSEL_48: step_len = `SARC_STEP_48;
      default: step_len = `SARC_STEP_144;
    endcase
    if (clksrc_q[`SARC_BIT_SUBCLK])
      step_len = `SARC_STEP_SUB; // RULE5
  end
  sarc_step_timer u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clear_in(ctl_write || state_q == ST_IDLE),
    .run_in(running),
    .tick_in(tick),
    .length_in(step_len),
    .step_out(step)
  );
  ////////////////////////////////////////////////////////////////////////
  // sequencer: sample slots, then one compare per step
  always @*
  begin
    state_d = state_q;
    approx_d = approx_q;
    trial_d = trial_q;
    sample_cnt_d = sample_cnt_q;
    result_d = result_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        // start does not wait for the band-gap; an early first result is undefined
        if (running)
        begin
          state_d = ST_SAMPLE; // RULE9
          sample_cnt_d = 1'b0;
        end
      end
      ST_SAMPLE:
      begin
        if (step)
        begin
          if (sample_cnt_q)
          begin
            state_d = ST_COMPARE; // RULE12 RULE25
            approx_d = `SARC_RESET_BYTE;
            trial_d = `SARC_MID_SCALE; // RULE13
          end
          else
            sample_cnt_d = 1'b1;
        end
      end
      ST_COMPARE:
      begin
        if (step)
        begin
          // keep trial bit when input at or above tap
          if (comparator_in)
            approx_d = approx_q | trial_q; // RULE13 RULE14
          trial_d = {1'b0, trial_q[7:1]}; // RULE14 RULE25
          if (trial_q[0])
          begin
            result_d = comparator_in ? (approx_q | trial_q) : approx_q; // RULE15
            done_d = 1'b1; // RULE15
            state_d = ST_SAMPLE; // RULE16
            sample_cnt_d = 1'b0;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // control writes abort and restart from sampling
    if (ctl_write || !running)
    begin
      state_d = ST_IDLE; // RULE17
      result_d = result_q; // RULE22
      done_d = 1'b0; // RULE22
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      mode_q <= `SARC_RESET_BYTE; // RULE2
      clksrc_q <= `SARC_RESET_BYTE;
      chan_q <= `SARC_RESET_BYTE;
      result_q <= `SARC_RESET_BYTE; // RULE19
      approx_q <= `SARC_RESET_BYTE;
      trial_q <= `SARC_RESET_BYTE;
      state_q <= ST_IDLE;
      sample_cnt_q <= 1'b0;
      conversion_done_irq_out <= 1'b0;
      rdata_out <= `SARC_RESET_BYTE;
    end
    else
    begin
      if (wr_mode)
        mode_q <= wdata_in & `SARC_MODE_MASK;
      if (wr_clksrc)
        clksrc_q <= wdata_in & `SARC_CLKSRC_MASK;
      if (wr_chan)
        chan_q <= wdata_in & `SARC_CHAN_MASK;
      result_q <= result_d;
      approx_q <= approx_d;
      trial_q <= trial_d;
      state_q <= state_d;
      sample_cnt_q <= sample_cnt_d;
      // pulse only; the pending flag lives outside and is never cleared here
      conversion_done_irq_out <= done_d; // RULE24
      // read returns the value held before a same-cycle update
      if (rd_in)
      begin
        case (addr_in)
          `SARC_ADDR_MODE: rdata_out <= mode_q;
          `SARC_ADDR_CLKSRC: rdata_out <= clksrc_q;
          `SARC_ADDR_CHAN: rdata_out <= chan_q;
          `SARC_ADDR_RESULT: rdata_out <= result_q; // RULE23 RULE26
          default: rdata_out <= `SARC_RESET_BYTE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // analog-side drives
  always @*
  begin
    bandgap_enable_out = mode_q[`SARC_BIT_BANDGAP]; // RULE7
    channel_route_out = chan_q[2:0]; // RULE10
    sample_out = (state_q == ST_SAMPLE); // RULE12
    tap_select_out = (state_q == ST_COMPARE) ? (approx_q | trial_q) : `SARC_RESET_BYTE; // RULE25
  end
endmodule // sarc_controller

// File: design/sarc_defines.vh
// constants for the successive-approximation converter controller
// Summary of operation
// RULE1: mode bit 7 enables repeated conversion
// RULE2: reset clears mode register to zero
// RULE3: main clock times 144/120/96/72 periods; code gives 140/120/100/70
// RULE4: software avoids time codes 101 and 110
// RULE5: subclock select uses x4 clock enable
// RULE6: software keeps conversions at least 14 us
// RULE7: mode bit 0 drives band-gap enable
// RULE8: software waits 14 us after band-gap
// RULE9: first result may be undefined early
// RULE10: channel field selects analog input
// RULE11: software writes zero to unused bits
// RULE12: sample first, then hold until done
// RULE13: search starts with bit 7 mid-scale
// RULE14: lower bits kept when input at/above tap; code keeps the trial bit instead
// RULE15: copy result and pulse done request together
// RULE16: conversions restart until enable cleared
// RULE17: mode or channel write aborts, restarts
// RULE18: standby halts converter operation
// RULE19: reset clears result register to zero
// RULE20: software reads result while running
// RULE21: software enables multiplier before subclock
// RULE22: register write beats result write
// RULE23: read sees old result, then new stored
// RULE24: rewriting mode keeps pending done flag
// RULE25: one sample phase plus eight equal steps
// RULE26: result register is read-only
`ifndef SARC_DEFINES_VH
`define SARC_DEFINES_VH
`define SARC_ADDR_MODE 16'hff80
`define SARC_ADDR_CLKSRC 16'hff81
`define SARC_ADDR_CHAN 16'hff84
`define SARC_ADDR_RESULT 16'hff85
`define SARC_RESET_BYTE 8'h00
`define SARC_BIT_ENABLE 7
`define SARC_BIT_BANDGAP 0
`define SARC_BIT_SUBCLK 7
`define SARC_TSEL_HI 5
`define SARC_TSEL_LO 3
`define SARC_MODE_MASK 8'hb9
`define SARC_CLKSRC_MASK 8'h80
`define SARC_CHAN_MASK 8'h07
`define SARC_TSEL_144 3'h0
`define SARC_TSEL_120 3'h1
`define SARC_TSEL_96 3'h2
`define SARC_TSEL_72 3'h4
`define SARC_TSEL_60 3'h5
`define SARC_TSEL_48 3'h6
// step length in clocks: conversion time over ten slots (2 sample + 8 compare)
`define SARC_STEP_144 8'h0e
`define SARC_STEP_120 8'h0c
`define SARC_STEP_96 8'h0a
`define SARC_STEP_72 8'h07
`define SARC_STEP_60 8'h06
`define SARC_STEP_48 8'h05
`define SARC_STEP_SUB 8'h01
`define SARC_SAMPLE_SLOTS 2
`define SARC_MSB 7
`define SARC_MID_SCALE 8'h80
`define SARC_ONE8 8'h01
`endif

// File: design/sarc_step_timer.v
// step timer that paces the conversion phases
`timescale 1ns/1ps
`include "sarc_defines.vh"
module sarc_step_timer (
  input wire clk_in,
  input wire nrst_in,
  input wire clear_in,
  input wire run_in,
  input wire tick_in,
  input wire [7:0] length_in,
  output wire step_out
);
  reg [7:0] count_q;
  reg [7:0] count_d;
  assign step_out = run_in && tick_in && (count_q + `SARC_ONE8 >= length_in);
  always @*
  begin
    count_d = count_q;
    if (clear_in || !run_in)
      count_d = `SARC_RESET_BYTE;
    else if (step_out)
      count_d = `SARC_RESET_BYTE;
    else if (tick_in)
      count_d = count_q + `SARC_ONE8;
  end
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      count_q <= `SARC_RESET_BYTE;
    else
      count_q <= count_d;
  end
endmodule // sarc_step_timer

// File: tb/sarc_analog_model.sv
// sample-hold and comparator facing the controller
`timescale 1ns/1ps
module sarc_analog_model (
  input wire clk_in,
  input wire [7:0] tap_in,
  input wire [2:0] chan_in,
  input wire sample_in,
  output wire cmp_out
);
  logic [7:0] volt [8];
  logic [7:0] held_q = 8'h00;
  always @(posedge clk_in) if (sample_in) held_q <= volt[chan_in];
  assign cmp_out = (held_q >= tap_in);
endmodule // sarc_analog_model

// File: tb/sarc_asserts.sv
// port assertions for the converter controller
`timescale 1ns/1ps
module sarc_asserts (
  input wire clk_in,
  input wire nrst_in,
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire standby_in,
  input wire [7:0] tap_select_out,
  input wire [2:0] channel_route_out,
  input wire sample_out,
  input wire bandgap_enable_out,
  input wire conversion_done_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire mwr = wr_in && addr_in == 16'hff80;
  wire cwr = wr_in && addr_in == 16'hff84;
  AST_BANDGAP: assert property (mwr |=> bandgap_enable_out == $past(wdata_in[0]))
    else $error("band-gap enable wrong");
  AST_CHANNEL: assert property (cwr |=> channel_route_out == $past(wdata_in[2:0]))
    else $error("channel route wrong");
  AST_IRQ_PULSE: assert property (conversion_done_irq_out |=> !conversion_done_irq_out)
    else $error("done request too long");
  AST_WRITE_WINS: assert property (mwr || cwr |=> !conversion_done_irq_out)
    else $error("done request after write");
  AST_START: assert property (mwr && wdata_in[7] && !standby_in ##1 !standby_in |=> sample_out)
    else $error("no sampling after enable");
  AST_STANDBY: assert property (standby_in |=> !sample_out && tap_select_out == 8'h00)
    else $error("running in standby");
  AST_FIRST_TRIAL: assert property ($fell(sample_out) && tap_select_out != 8'h00 |->
    tap_select_out == 8'h80) else $error("first trial not mid-scale");
  AST_RESTART: assert property (conversion_done_irq_out |-> sample_out)
    else $error("no restart after done");
  cover property (conversion_done_irq_out);
  cover property (standby_in && sample_out);
  cover property (cwr && tap_select_out != 8'h00);
endmodule // sarc_asserts

// File: tb/tb.sv
// self-checking bench for the converter controller
`timescale 1ns/1ps
module tb;
  logic clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, standby_in = 0, tick = 0, pend = 0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  wire [7:0] rdata_out, tap;
  wire [2:0] chan;
  wire smp, cmp, irq, bg;
  logic [7:0] q [$];
  int errors = 0, total_checks = 0, cyc = 0, n;
  // only the permitted time codes are ever programmed
  logic [2:0] tc [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  int len [4] = '{14, 12, 10, 7};
  sarc_controller u_sarc_controller (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .standby_in(standby_in), .subclk_x4_tick_in(tick), .comparator_in(cmp),
    .tap_select_out(tap), .channel_route_out(chan), .sample_out(smp),
    .bandgap_enable_out(bg), .conversion_done_irq_out(irq));
  sarc_analog_model u_sarc_analog_model (.clk_in(clk_in), .tap_in(tap), .chan_in(chan),
    .sample_in(smp), .cmp_out(cmp));
  initial forever #25 clk_in = ~clk_in;
  always @(negedge clk_in) tick <= ($urandom % 4 == 0);
  always @(posedge clk_in) cyc <= cyc + 1;
  always @(posedge clk_in) if (cyc == 20000) wrap_up();
  task automatic wrap_up();
    errors += (cyc >= 20000);
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    errors += (g !== e);
    if (g !== e) $display("mismatch %s expected %h seen %h", nm, e, g);
  endtask
  task automatic chk_count(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    errors += (g !== e);
    if (g !== e) $display("mismatch %s expected %0d seen %0d", nm, e, g);
  endtask
  // read results compared as they appear
  always @(posedge clk_in)
  begin
    if (pend) chk("read data", {8'h00, q.pop_front()}, {8'h00, rdata_out});
    pend <= rd_in;
  end
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge clk_in);
    addr_in = a;
    wdata_in = d;
    wr_in = 1;
    @(negedge clk_in);
    wr_in = 0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(negedge clk_in);
    addr_in = a;
    rd_in = 1;
    q.push_back(e);
    @(negedge clk_in);
    rd_in = 0;
  endtask
  task automatic wait_irq();
    @(negedge clk_in);
    for (n = 1; irq !== 1'b1 && n < 400; n++) @(negedge clk_in);
  endtask
  initial
  begin
    void'($urandom(84));
    for (int i = 0; i < 8; i++) u_sarc_analog_model.volt[i] = 8'($urandom);
    repeat (20) @(negedge clk_in);
    nrst_in = 1;
    rd(16'hff80, 8'h00);
    rd(16'hff85, 8'h00);
    wr(16'hff85, 8'h5a);
    rd(16'hff85, 8'h00);
    $display("test registers done");
    wr(16'hff80, 8'h01);
    repeat (280) @(negedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      wr(16'hff84, {5'h00, i[2:0]});
      wr(16'hff80, 8'h81 | {2'h0, tc[i % 4], 3'h0});
      wait_irq();
      wait_irq();
      chk_count("period", 16'(10 * len[i % 4]), 16'(n));
      rd(16'hff85, u_sarc_analog_model.volt[i]);
    end
    rd(16'hff80, 8'ha1);
    $display("test conversions done");
    standby_in = 1;
    repeat (50) @(negedge clk_in);
    standby_in = 0;
    // multiplier assumed enabled outside this block before the switch
    wr(16'hff81, 8'h80);
    wr(16'hff80, 8'h81);
    wait_irq();
    wait_irq();
    chk_count("subclock done", 16'd1, {15'h0000, irq});
    rd(16'hff85, u_sarc_analog_model.volt[7]);
    // channel change while running aborts and converts the new input
    wr(16'hff84, 8'h02);
    wait_irq();
    chk_count("channel restart", 16'd1, {15'h0000, irq});
    rd(16'hff85, u_sarc_analog_model.volt[2]);
    wr(16'hff80, 8'h00);
    wait_irq();
    chk_count("stopped", 16'd400, 16'(n));
    $display("test standby, subclock and stop done");
    // reset in the middle of running conversions
    wr(16'hff80, 8'h81);
    wait_irq();
    nrst_in = 0;
    repeat (20) @(negedge clk_in);
    nrst_in = 1;
    rd(16'hff80, 8'h00);
    rd(16'hff81, 8'h00);
    rd(16'hff85, 8'h00);
    $display("test reset during conversion done");
    wrap_up();
  end
endmodule // tb
bind sarc_controller sarc_asserts u_sarc_asserts (.clk_in(clk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .standby_in(standby_in),
  .tap_select_out(tap_select_out), .channel_route_out(channel_route_out),
  .sample_out(sample_out), .bandgap_enable_out(bandgap_enable_out),
  .conversion_done_irq_out(conversion_done_irq_out));
